// File: inc/pdm_conv_pkg.sv
package pdm_conv_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int PAIRS = 4;
    localparam int PCM_W = 24;
    localparam int ACC_W = 9;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLKCFG = 8'h04;
    localparam logic [7:0] OFS_GAIN = 8'h08;
    localparam logic [7:0] OFS_VOLUME = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PCM_BASE = 8'h20;
    localparam logic [7:0] OFS_PCM_END = 8'h3c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_STEREO_BIT = 2;
    localparam int CTRL_SWAP_BIT = 3;
    localparam int CLK_PRE_LSB = 0;
    localparam int CLK_DIV_LSB = 4;
    localparam int CLK_DEC_LSB = 8;
    localparam int RIGHT_LSB = 8;
    localparam int STAT_CNT_LSB = 16;

    // ----------------------------------------------------------------
    // Conversion modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DOWN = 2'b00,
        MODE_REDUCED = 2'b01,
        MODE_MID = 2'b10,
        MODE_HIGH = 2'b11
    } perf_mode_e;

    typedef enum logic {
        ST_DOWN = 1'b0,
        ST_RUN = 1'b1
    } conv_state_e;

    // ----------------------------------------------------------------
    // Reset values: 1.024 MHz mic clock, decimation 32, 16 kHz
    // ----------------------------------------------------------------
    localparam logic [1:0] PRE_RST = 2'h1;
    localparam logic [3:0] DIV_RST = 4'hb;
    localparam logic [6:0] DEC_RST = 7'h20;
    localparam logic [4:0] GAIN_RST = 5'h08;
    localparam logic [7:0] VOL_RST = 8'h80;

    // ----------------------------------------------------------------
    // Gain arithmetic: four 1.5 dB steps make one 6 dB shift
    // ----------------------------------------------------------------
    localparam int PCM_SHIFT = 15;
    localparam int MANT_FRAC = 8;
    localparam int VOL_FRAC = 7;
    localparam int GAIN_BASE_SHIFT = 2;
    localparam logic [8:0] GAIN_MANT [4] = '{9'h100, 9'h130, 9'h16a, 9'h1af};

endpackage

// File: logic/pdm_conv.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_conv #(
    parameter int PAIRS = pdm_conv_pkg::PAIRS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Microphone link
    output logic mic_sample_clock,
    input wire logic [PAIRS-1:0] mic_data,
    // PCM stream
    output logic [PAIRS-1:0][pdm_conv_pkg::PCM_W-1:0] pcm_left,
    output logic [PAIRS-1:0][pdm_conv_pkg::PCM_W-1:0] pcm_right,
    output logic pcm_valid
);
    import pdm_conv_pkg::*;

    // ----------------------------------------------------------------
    // Gain and volume stage
    // ----------------------------------------------------------------
    // Mantissa picks the 1.5 dB step, shift the 6 dB octave, then volume.
    function automatic logic [PCM_W-1:0] apply_gain(
        input logic signed [ACC_W-1:0] sum,
        input logic [4:0] g,
        input logic [7:0] vol
    );
        logic signed [47:0] x;
        logic signed [47:0] lim;
        x = 48'(sum) <<< PCM_SHIFT;
        x = x * $signed({1'b0, GAIN_MANT[g[1:0]]});
        x = (x <<< g[4:2]) >>> (MANT_FRAC + GAIN_BASE_SHIFT);
        x = (x * $signed({1'b0, vol})) >>> VOL_FRAC;
        lim = 48'sd1 <<< (PCM_W - 1);
        if (x >= lim) begin
            x = lim - 48'sd1;
        end else if (x < -lim) begin
            x = -lim;
        end
        return x[PCM_W-1:0];
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    perf_mode_e mode, next_mode;
    logic stereo, next_stereo;
    logic swap, next_swap;
    logic [1:0] pre, next_pre;
    logic [3:0] div, next_div;
    logic [6:0] dec, next_dec;
    logic [4:0] gain_l, next_gain_l;
    logic [4:0] gain_r, next_gain_r;
    logic [7:0] vol_l, next_vol_l;
    logic [7:0] vol_r, next_vol_r;
    logic [15:0] sample_cnt, next_sample_cnt;
    logic wr_en;
    logic rd_hit;
    logic [31:0] rd_word;
    logic [2:0] pcm_idx;
    conv_state_e state, next_state;

    assign wr_en = psel && penable && pwrite;
    assign pcm_idx = 3'(paddr[7:2] - OFS_PCM_BASE[7:2]);

    // Register writes; only full-word writes, no byte strobes on this bus
    always_comb begin
        next_mode = mode;
        next_stereo = stereo;
        next_swap = swap;
        next_pre = pre;
        next_div = div;
        next_dec = dec;
        next_gain_l = gain_l;
        next_gain_r = gain_r;
        next_vol_l = vol_l;
        next_vol_r = vol_r;
        if (wr_en) begin
            case (paddr)
                OFS_CTRL: begin
                    next_mode = perf_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
                    next_stereo = pwdata[CTRL_STEREO_BIT];
                    next_swap = pwdata[CTRL_SWAP_BIT];
                end
                OFS_CLKCFG: begin
                    next_pre = pwdata[CLK_PRE_LSB +: 2];
                    next_div = pwdata[CLK_DIV_LSB +: 4];
                    next_dec = pwdata[CLK_DEC_LSB +: 7];
                end
                OFS_GAIN: begin
                    next_gain_l = pwdata[0 +: 5];
                    next_gain_r = pwdata[RIGHT_LSB +: 5];
                end
                OFS_VOLUME: begin
                    next_vol_l = pwdata[0 +: 8];
                    next_vol_r = pwdata[RIGHT_LSB +: 8];
                end
                default: begin
                    next_mode = mode;
                end
            endcase
        end
    end

    // Register storage; reset settings give the voice rate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode <= MODE_DOWN;
            stereo <= 1'b1;
            swap <= 1'b0;
            pre <= PRE_RST;
            div <= DIV_RST;
            dec <= DEC_RST;
            gain_l <= GAIN_RST;
            gain_r <= GAIN_RST;
            vol_l <= VOL_RST;
            vol_r <= VOL_RST;
        end else begin
            mode <= next_mode;
            stereo <= next_stereo;
            swap <= next_swap;
            pre <= next_pre;
            div <= next_div;
            dec <= next_dec;
            gain_l <= next_gain_l;
            gain_r <= next_gain_r;
            vol_l <= next_vol_l;
            vol_r <= next_vol_r;
        end
    end

    // Read mux; unmapped addresses answer with an error and zero data
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: begin
                rd_word[CTRL_MODE_LSB +: 2] = mode;
                rd_word[CTRL_STEREO_BIT] = stereo;
                rd_word[CTRL_SWAP_BIT] = swap;
            end
            OFS_CLKCFG: begin
                rd_word[CLK_PRE_LSB +: 2] = pre;
                rd_word[CLK_DIV_LSB +: 4] = div;
                rd_word[CLK_DEC_LSB +: 7] = dec;
            end
            OFS_GAIN: begin
                rd_word[0 +: 5] = gain_l;
                rd_word[RIGHT_LSB +: 5] = gain_r;
            end
            OFS_VOLUME: begin
                rd_word[0 +: 8] = vol_l;
                rd_word[RIGHT_LSB +: 8] = vol_r;
            end
            OFS_STATUS: begin
                rd_word[0] = state;
                rd_word[1] = mic_sample_clock;
                rd_word[STAT_CNT_LSB +: 16] = sample_cnt;
            end
            default: begin
                if (paddr >= OFS_PCM_BASE && paddr <= OFS_PCM_END && paddr[1:0] == 2'b00) begin
                    if (pcm_idx[0] == 1'b0) begin
                        rd_word = 32'(pcm_left[pcm_idx[2:1]]);
                    end else begin
                        rd_word = 32'(pcm_right[pcm_idx[2:1]]);
                    end
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_hit;
    assign prdata = (psel && penable && !pwrite && rd_hit) ? rd_word : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Run state
    // ----------------------------------------------------------------
    // Conversion runs in any mode but power-down
    always_comb begin
        case (state)
            ST_DOWN: next_state = (mode != MODE_DOWN) ? ST_RUN : ST_DOWN;
            ST_RUN: next_state = (mode == MODE_DOWN) ? ST_DOWN : ST_RUN;
            default: next_state = ST_DOWN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_DOWN;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Clock dividers
    // ----------------------------------------------------------------
    logic [1:0] pre_cnt, next_pre_cnt;
    logic [3:0] phase, next_phase;
    logic next_mic_clk;
    logic [7:0] osr_cnt, next_osr_cnt;
    logic core_tick;
    logic [4:0] half;
    logic rise_ev;
    logic fall_ev;
    logic frame_end;

    assign core_tick = (state == ST_RUN) && (pre_cnt == pre);
    assign half = 5'((5'(div) + 5'h01) >> 1);
    assign rise_ev = core_tick && (phase == div);
    assign fall_ev = core_tick && (5'(phase) + 5'h01 == half);
    // At-or-past end, so a smaller decimation mid-frame cannot wrap the count
    assign frame_end = fall_ev && (osr_cnt >= 8'({dec, 1'b0} - 8'h01));

    // Predivider, divider phase and oversampling count
    always_comb begin
        next_pre_cnt = pre_cnt;
        next_phase = phase;
        next_mic_clk = 1'b0;
        next_osr_cnt = osr_cnt;
        if (state == ST_RUN) begin
            next_pre_cnt = core_tick ? 2'h0 : 2'(pre_cnt + 2'h1);
            if (core_tick) begin
                next_phase = (phase == div) ? 4'h0 : 4'(phase + 4'h1);
            end
            next_mic_clk = (5'(next_phase) < half);
            if (frame_end) begin
                next_osr_cnt = 8'h00;
            end else if (fall_ev) begin
                next_osr_cnt = 8'(osr_cnt + 8'h01);
            end
        end else begin
            next_pre_cnt = 2'h0;
            next_phase = 4'h0;
            next_osr_cnt = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre_cnt <= 2'h0;
            phase <= 4'h0;
            mic_sample_clock <= 1'b0;
            osr_cnt <= 8'h00;
        end else begin
            pre_cnt <= next_pre_cnt;
            phase <= next_phase;
            mic_sample_clock <= next_mic_clk;
            osr_cnt <= next_osr_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Edge capture and sample count
    // ----------------------------------------------------------------
    logic [PAIRS-1:0] rise_bits, next_rise_bits;
    logic next_pcm_valid;

    // Rising-edge bits are held until the falling edge completes the pair
    always_comb begin
        next_rise_bits = rise_ev ? mic_data : rise_bits;
        next_pcm_valid = frame_end;
        next_sample_cnt = frame_end ? 16'(sample_cnt + 16'h0001) : sample_cnt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rise_bits <= '0;
            pcm_valid <= 1'b0;
            sample_cnt <= 16'h0000;
        end else begin
            rise_bits <= next_rise_bits;
            pcm_valid <= next_pcm_valid;
            sample_cnt <= next_sample_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Per-pair decimation and gain
    // ----------------------------------------------------------------
    // Boxcar decimator over 2*dec mic periods; cheap, but aliases more
    // than a multi-stage sinc would.
    genvar p;
    generate
        for (p = 0; p < PAIRS; p++) begin : g_pair
            logic signed [ACC_W-1:0] acc_l, next_acc_l;
            logic signed [ACC_W-1:0] acc_r, next_acc_r;
            logic [PCM_W-1:0] next_left;
            logic [PCM_W-1:0] next_right;
            logic [PCM_W-1:0] left_q;
            logic [PCM_W-1:0] right_q;
            logic bit_l;
            logic bit_r;
            logic signed [ACC_W-1:0] sum_l;
            logic signed [ACC_W-1:0] sum_r;

            // Edge-to-channel routing
            always_comb begin
                bit_l = swap ? mic_data[p] : rise_bits[p];
                bit_r = swap ? rise_bits[p] : mic_data[p];
                sum_l = acc_l + (bit_l ? 9'sd1 : -9'sd1);
                sum_r = acc_r + (bit_r ? 9'sd1 : -9'sd1);
                next_acc_l = acc_l;
                next_acc_r = acc_r;
                next_left = left_q;
                next_right = right_q;
                if (state != ST_RUN) begin
                    next_acc_l = '0;
                    next_acc_r = '0;
                end else if (frame_end) begin
                    next_acc_l = '0;
                    next_acc_r = '0;
                    next_left = apply_gain(sum_l, gain_l, vol_l);
                    next_right = stereo ? apply_gain(sum_r, gain_r, vol_r) : '0;
                end else if (fall_ev) begin
                    next_acc_l = sum_l;
                    next_acc_r = stereo ? sum_r : '0;
                end
                // Mono clears the right word at the frame edge, so words only move with pcm_valid
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    acc_l <= '0;
                    acc_r <= '0;
                    left_q <= '0;
                    right_q <= '0;
                end else begin
                    acc_l <= next_acc_l;
                    acc_r <= next_acc_r;
                    left_q <= next_left;
                    right_q <= next_right;
                end
            end

            // One driver per output slice; the words come straight from the flops
            assign pcm_left[p] = left_q;
            assign pcm_right[p] = right_q;
        end
    endgenerate

endmodule
`default_nettype wire

// File: sim/pdm_conv_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_conv_properties #(
    parameter int PAIRS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Microphone link
    input wire logic mic_sample_clock,
    input wire logic [PAIRS-1:0] mic_data,
    // PCM stream
    input wire logic [PAIRS-1:0][pdm_conv_pkg::PCM_W-1:0] pcm_left,
    input wire logic [PAIRS-1:0][pdm_conv_pkg::PCM_W-1:0] pcm_right,
    input wire logic pcm_valid
);
    import pdm_conv_pkg::*;
    logic acc;
    logic rd;
    logic mapped;
    // Misaligned PCM offsets count as unmapped, so they must be refused too
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = (paddr inside {OFS_CTRL, OFS_CLKCFG, OFS_GAIN, OFS_VOLUME, OFS_STATUS})
        || (paddr >= OFS_PCM_BASE && paddr <= OFS_PCM_END && paddr[1:0] == 2'b00);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------
    // Properties
    // ------------------------
    a_zero_wait: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
    a_err_quiet: assert property (!(acc && !mapped) |-> !pslverr) else $error("stray pslverr");
    a_rdata_idle: assert property (!rd |-> prdata == 32'h0) else $error("prdata not zero");
    a_left_readback:
        assert property (rd && paddr == OFS_PCM_BASE |-> prdata == {8'h00, pcm_left[0]})
        else $error("left word readback differs");
    a_right_readback:
        assert property (rd && paddr == 8'h24 |-> prdata == {8'h00, pcm_right[0]})
        else $error("right word readback differs");
    a_valid_pulse:
        assert property (pcm_valid |=> !pcm_valid) else $error("pcm_valid too long");
    a_words_hold:
        assert property (!pcm_valid |-> $stable(pcm_left) && $stable(pcm_right))
        else $error("pcm words moved without pcm_valid");
    a_clk_high_half:
        assert property ($rose(mic_sample_clock) |-> ##[1:40] !mic_sample_clock)
        else $error("mic clock stuck high");
    a_down_idle:
        assert property (acc && pwrite && paddr == OFS_CTRL && pwdata[1:0] == 2'b00
            |-> ##3 !mic_sample_clock [*8]) else $error("mic clock runs in power-down");
    // Main scenarios reached
    c_frame: cover property (pcm_valid);
    c_refused: cover property (acc && pslverr);
    c_clk_fall: cover property ($fell(mic_sample_clock));
endmodule
bind pdm_conv pdm_conv_properties #(.PAIRS(PAIRS)) pdm_conv_properties_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mic_sample_clock(mic_sample_clock), .mic_data(mic_data), .pcm_left(pcm_left),
    .pcm_right(pcm_right), .pcm_valid(pcm_valid)
);
`default_nettype wire

// File: sim/pdm_mic_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_mic_model #(
    parameter int PAIRS = 4
) (
    // Clock from the converter
    input wire logic mic_sample_clock,
    // Bits sent by the rising-edge and falling-edge microphone of each pair
    input wire logic [PAIRS-1:0] rise_bits,
    input wire logic [PAIRS-1:0] fall_bits,
    // Shared data lines
    output logic [PAIRS-1:0] mic_data
);
    // Each mic owns one half period; the partner takes over, so the line never floats
    always_comb begin
        mic_data = mic_sample_clock ? fall_bits : rise_bits;
    end
endmodule
`default_nettype wire

// File: sim/pdm_conv_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_conv_tb;
    import pdm_conv_pkg::*;
    localparam int DEC = 16;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, pcm_valid, mic_sample_clock;
    logic last_mck, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [PAIRS-1:0] mic_data, rise_bits, fall_bits;
    logic [PAIRS-1:0][PCM_W-1:0] pcm_left, pcm_right;
    int n_fail = 0, checked = 0, cyc = 0, t0, n;
    int rows [5][3] = '{'{1, 11, 32}, '{1, 3, 32}, '{1, 1, 32}, '{1, 15, 24}, '{1, 7, 16}};
    logic [3:0] cc [6] = '{4'h7, 4'hf, 4'h3, 4'hb, 4'h5, 4'h6};
    logic [15:0] gg [6] = '{16'h0808, 16'h0808, 16'h0808, 16'h0808, 16'h1f00, 16'h0808};
    logic [15:0] vv [6] = '{16'h8080, 16'h8080, 16'h8080, 16'h8080, 16'h8080, 16'h8040};
    pdm_conv pdm_conv_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mic_sample_clock(mic_sample_clock), .mic_data(mic_data),
        .pcm_left(pcm_left), .pcm_right(pcm_right), .pcm_valid(pcm_valid));
    pdm_mic_model pdm_mic_model_inst (.mic_sample_clock(mic_sample_clock),
        .rise_bits(rise_bits), .fall_bits(fall_bits), .mic_data(mic_data));
    // ------------------------
    // Tasks
    // ------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen; data and response taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_valid(input int k);
        int m;
        repeat (k) begin
            m = 0;
            do begin @(posedge ref_clk); m++; end while (pcm_valid !== 1'b1 && m < 4000);
            if (m >= 4000) n_fail++;
        end
    endtask
    task automatic wait_rise();
        int m;
        m = 0;
        do begin @(posedge ref_clk); m++; end
        while (!(mic_sample_clock === 1'b1 && last_mck === 1'b0) && m < 300);
    endtask
    // Sum of +-1 over the frame, then gain mantissa and shift, then volume
    function automatic logic [23:0] pcmv(input logic b, input logic [4:0] g,
            input logic [7:0] v);
        longint x;
        x = b ? 2 * DEC : -2 * DEC;
        x = (x <<< 15) * longint'(GAIN_MANT[g[1:0]]) / 256;
        x = (x <<< g[4:2]) >>> 2;
        x = x * longint'(v) / 128;
        if (x > 64'sh7fffff) x = 64'sh7fffff;
        if (x < -64'sh800000) x = -64'sh800000;
        return x[23:0];
    endfunction
    task automatic run_case(input logic [3:0] c, input logic [15:0] g, input logic [15:0] v);
        logic l, r;
        apb(1'b1, OFS_GAIN, {16'h0, g}, q);
        apb(1'b1, OFS_VOLUME, {16'h0, v}, q);
        apb(1'b1, OFS_CTRL, {28'h0, c}, q);
        wait_valid(3);
        for (int p = 0; p < PAIRS; p++) begin
            l = c[3] ? fall_bits[p] : rise_bits[p];
            r = c[3] ? rise_bits[p] : fall_bits[p];
            chk(pcm_left[p], pcmv(l, g[4:0], v[7:0]));
            chk(pcm_right[p], c[2] ? pcmv(r, g[12:8], v[15:8]) : 24'h0);
            apb(1'b0, OFS_PCM_BASE + 8'(8 * p), 32'h0, q);
            chk(q, {8'h0, pcmv(l, g[4:0], v[7:0])});
        end
        $display("case ctrl=%h gain=%h vol=%h done", c, g, v);
    endtask
    task automatic finish_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------
    // Clock, counters, watchdog
    // ------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        last_mck <= mic_sample_clock;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        finish_test();
    end
    // ------------------------
    // Test sequence
    // ------------------------
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        rise_bits = 4'b0101;
        fall_bits = 4'b0011;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0, q);
        chk(q, 32'h4);
        apb(1'b0, OFS_CLKCFG, 32'h0, q);
        chk(q, 32'h20b1);
        apb(1'b0, OFS_GAIN, 32'h0, q);
        chk(q, 32'h0808);
        apb(1'b0, OFS_VOLUME, 32'h0, q);
        chk(q, 32'h8080);
        apb(1'b0, 8'h22, 32'h0, q);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h14, 32'h0, q);
        chk({q[31:1], err}, 32'h1);
        $display("reset and map test done");
        apb(1'b1, OFS_CTRL, 32'h6, q);
        foreach (rows[i]) begin
            apb(1'b1, OFS_CLKCFG, 32'(rows[i][2] << 8 | rows[i][1] << 4 | rows[i][0]), q);
            wait_rise();
            wait_rise();
            t0 = cyc;
            wait_rise();
            chk(32'(cyc - t0), 32'((rows[i][0] + 1) * (rows[i][1] + 1)));
            wait_valid(2);
            t0 = cyc;
            wait_valid(1);
            chk(32'(cyc - t0), 32'((rows[i][0] + 1) * (rows[i][1] + 1) * 2 * rows[i][2]));
        end
        $display("clock ratio test done");
        apb(1'b1, OFS_CLKCFG, 32'h1010, q);
        foreach (cc[i]) run_case(cc[i], gg[i], vv[i]);
        apb(1'b0, OFS_STATUS, 32'h0, q);
        chk(32'(q[0]), 32'h1);
        apb(1'b1, OFS_CTRL, 32'h4, q);
        n = 0;
        repeat (2) @(posedge ref_clk);
        repeat (64) begin
            @(posedge ref_clk);
            if (mic_sample_clock !== 1'b0 || pcm_valid !== 1'b0) n++;
        end
        chk(32'(n), 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0, q);
        chk(32'(q[1:0]), 32'h0);
        $display("power-down test done");
        finish_test();
    end
endmodule
`default_nettype wire
